// [rtl/sbc_pkg.sv]
/*
 Shared definitions for the status byte and common command block:
 command codes, controller states, status byte layout and carriers.
 Assumes a command parser on the same clock that delivers decoded commands.
*/
`default_nettype none

package sbc_pkg;

    localparam int unsigned SET_W     = 32;   // Width of one saved instrument state
    localparam int unsigned SLOTS     = 4;    // Nonvolatile state slots
    localparam int unsigned SLOT_W    = 2;

    // Status byte bit positions
    localparam int unsigned BIT_OPSUM = 7;
    localparam int unsigned BIT_MSS   = 6;
    localparam int unsigned BIT_ESB   = 5;
    localparam int unsigned BIT_MAV   = 4;
    localparam int unsigned BIT_QSUM  = 3;

    localparam logic [7:0] BYTE_ZERO  = 8'h00;
    localparam logic [7:0] RESP_PASS  = 8'h00;
    localparam logic [7:0] RESP_FAIL  = 8'h01;
    localparam logic [7:0] SLOT_LIMIT = 8'h03;
    localparam logic [1:0] SLOT_ZERO  = 2'h0;
    // Summary bits that may feed the master summary (bit 6 excluded)
    localparam logic [7:0] SUM_MASK   = 8'hB8;

    typedef logic [SET_W-1:0] settings_t;

    typedef enum logic [2:0]
    {
        CMD_SAV     = 3'h0,
        CMD_MASK_SET = 3'h1,
        CMD_MASK_QRY = 3'h2,
        CMD_STAT_QRY = 3'h3,
        CMD_TRG     = 3'h4,
        CMD_TST     = 3'h5,
        CMD_WAI     = 3'h6,
        CMD_CLS     = 3'h7
    } cmd_t;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1,
        ST_TEST = 2'h2
    } state_t;

    // Summary levels from the event register groups; each drops when its
    // event register is read, which happens outside this block.
    typedef struct packed
    {
        logic operation_summary;
        logic event_summary;
        logic questionable_summary;
    } summary_t;

    typedef struct packed
    {
        logic       valid;
        logic [7:0] data;
    } resp_t;

endpackage : sbc_pkg

`default_nettype wire

// [rtl/status_byte_common_commands.sv]
/*
 Status byte, service request and common command handling: state save and
 power-on recall, request mask, status query, serial poll, bus trigger,
 self-test query and wait-for-pending.
 Assumes every input comes from logic on clk_i (command parser, bus
 interface, event registers, output queue), so none is synchronised.
*/

// What this block does
// - Save settings into one of four slots
// - Power-on restores slot zero when selected
// - Request mask loads 0-255, query returns it
// - OR of masked status bits sets bit 6
// - Serial poll clears request bit, keeps summary
// - Mask zero never raises a service request
// - Status query returns byte without clearing it
// - Summary bits clear only via event reads
// - Message bit clears at reset, clear, empty
// - Fixed status byte bit layout, low zeros
// - Serial poll byte carries request bit six
// - Bus trigger fires only with bus source
// - Self-test answers 0 or 1, logs failures
// - Wait stalls commands until pending ops done
// - Only device clear aborts a stalled wait
// - Pending includes overlapped and trigger actions
// - Power-on clears or restores the masks
`default_nettype none

module status_byte_common_commands
    import sbc_pkg::*;
(
    input  wire logic              clk_i,                // 200 MHz system clock
    input  wire logic              resetn_i,             // Power-on reset, low
    input  wire logic              cmd_valid_i,          // Command offered
    input  wire sbc_pkg::cmd_t     cmd_code_i,           // Decoded command
    input  wire logic [7:0]        cmd_param_i,          // Numeric parameter
    output logic                   cmd_ready_o,          // Command accepted
    input  wire sbc_pkg::settings_t settings_i,          // Present instrument state
    input  wire logic              power_on_state_select_i, // 1: recall_slot_zero
    input  wire logic              psc_i,                // 1: clear masks at power-on
    output logic                   restore_valid_o,      // Restore pulse
    output sbc_pkg::settings_t     restore_data_o,       // State to restore
    output logic                   mask_clear_o,         // Clear event enable mask
    input  wire sbc_pkg::summary_t summary_i,            // Summary levels
    input  wire logic              oq_has_data_i,        // Output queue not empty
    input  wire logic              spoll_i,              // Serial poll pulse
    input  wire logic              dcl_i,                // Device clear pulse
    input  wire logic              get_i,                // Group execute trigger
    input  wire logic              trig_source_bus_i,    // Trigger source is bus
    input  wire logic              pending_busy_i,       // Overlapped or trigger work
    input  wire logic              selftest_err_valid_i, // Self-test failure pulse
    input  wire logic [7:0]        selftest_err_code_i,  // Failure code
    input  wire logic              selftest_done_i,      // Self-test finished
    output logic                   selftest_start_o,     // Start self-test pulse
    output logic                   err_push_o,           // Error queue push
    output logic [7:0]             err_code_o,           // Error queue code
    output logic                   spoll_valid_o,        // Serial poll answer
    output logic [7:0]             spoll_data_o,         // Serial poll byte
    output sbc_pkg::resp_t         resp_o,               // Query answer
    output logic [7:0]             status_o,             // Status byte, query view
    output logic [7:0]             mask_o,               // Request mask
    output logic                   srq_o,                // Service request
    output logic                   trigger_o             // Trigger pulse
);
    import sbc_pkg::*;

    // Nonvolatile storage; deliberately not reset so it survives power-on
    settings_t  slot_mem [SLOTS];
    logic [7:0] mask_nv;

    state_t     state;
    state_t     next_state;
    logic       pon;
    logic       mss;
    logic       mav;
    logic       rqs;
    logic       test_fail;
    logic [7:0] mask;
    logic [7:0] status_byte;

    function automatic logic is_cmd(input logic v, input cmd_t c, input cmd_t want);
        is_cmd = v && (c == want);
    endfunction : is_cmd

    wire logic       take      = cmd_valid_i && cmd_ready_o;
    wire logic       take_sav  = is_cmd(take, cmd_code_i, CMD_SAV);
    wire logic       take_mask = is_cmd(take, cmd_code_i, CMD_MASK_SET);
    wire logic       take_mskq = is_cmd(take, cmd_code_i, CMD_MASK_QRY);
    wire logic       take_stq  = is_cmd(take, cmd_code_i, CMD_STAT_QRY);
    wire logic       take_trg  = is_cmd(take, cmd_code_i, CMD_TRG);
    wire logic       take_tst  = is_cmd(take, cmd_code_i, CMD_TST);
    wire logic       take_wai  = is_cmd(take, cmd_code_i, CMD_WAI);
    wire logic       take_cls  = is_cmd(take, cmd_code_i, CMD_CLS);
    wire logic       slot_ok   = cmd_param_i <= SLOT_LIMIT;
    wire logic [1:0] slot_sel  = cmd_param_i[SLOT_W-1:0];

    // Mask applied from the next edge on
    wire logic [7:0] pon_mask  = psc_i ? BYTE_ZERO : mask_nv;
    wire logic [7:0] next_mask = pon ? pon_mask : (take_mask ? cmd_param_i : mask);

    // Message bit follows the queue and drops on a clear command
    wire logic       next_mav  = oq_has_data_i && !take_cls;

    // Summary bits are passed straight through; their owners clear them
    wire logic [7:0] raw_stat  = {summary_i.operation_summary, 1'h0,
                                  summary_i.event_summary, next_mav,
                                  summary_i.questionable_summary, 3'h0};
    wire logic       next_mss  = |(raw_stat & next_mask & SUM_MASK);
    wire logic [7:0] next_stat = {raw_stat[7], next_mss, raw_stat[5:0]};

    // A new request only on a rising summary; a fresh rise beats a poll clear
    wire logic       rqs_set   = next_mss && !mss;
    wire logic       next_rqs  = rqs_set || (rqs && !spoll_i);

    wire logic       wait_done = !pending_busy_i;
    wire logic       trig_fire = (take_trg || get_i) && trig_source_bus_i;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (take_wai)
                    next_state = ST_WAIT;
                else if (take_tst)
                    next_state = ST_TEST;
            end
            ST_WAIT:
            begin
                if (dcl_i || wait_done)
                    next_state = ST_IDLE;
            end
            ST_TEST:
            begin
                if (selftest_done_i)
                    next_state = ST_IDLE;
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= ST_IDLE;
            pon   <= 1'h1;
        end
        else
        begin
            state <= next_state;
            pon   <= 1'h0;
        end
    end

    // Command intake stalls outside idle and during the power-on cycle
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cmd_ready_o <= 1'h0;
        else
            cmd_ready_o <= (next_state == ST_IDLE);
    end

    always_ff @(posedge clk_i)
    begin
        if (take_sav && slot_ok)
            slot_mem[slot_sel] <= settings_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (take_mask)
            mask_nv <= cmd_param_i;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            restore_valid_o <= 1'h0;
            restore_data_o  <= '0;
            mask_clear_o    <= 1'h0;
        end
        else
        begin
            restore_valid_o <= pon && power_on_state_select_i;
            restore_data_o  <= slot_mem[SLOT_ZERO];
            mask_clear_o    <= pon && psc_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mask        <= BYTE_ZERO;
            mav         <= 1'h0;
            mss         <= 1'h0;
            rqs         <= 1'h0;
            status_byte <= BYTE_ZERO;
        end
        else
        begin
            mask        <= next_mask;
            mav         <= next_mav;
            mss         <= next_mss;
            rqs         <= next_rqs;
            status_byte <= next_stat;
        end
    end

    assign status_o = status_byte;
    assign mask_o   = mask;
    assign srq_o = rqs;

    // Poll answer uses the request bit as it stood when the poll came in
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            spoll_valid_o <= 1'h0;
            spoll_data_o  <= BYTE_ZERO;
        end
        else
        begin
            spoll_valid_o <= spoll_i;
            spoll_data_o  <= {status_byte[BIT_OPSUM], rqs, status_byte[BIT_ESB:0]};
        end
    end

    // Queries; status read leaves every bit untouched
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            resp_o <= '0;
        else if (take_mskq)
            resp_o <= '{valid: 1'h1, data: mask};
        else if (take_stq)
            resp_o <= '{valid: 1'h1, data: status_byte};
        else if (state == ST_TEST && selftest_done_i)
            resp_o <= '{valid: 1'h1,
                        data: (test_fail || selftest_err_valid_i) ? RESP_FAIL : RESP_PASS};
        else
            resp_o <= '0;
    end

    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            selftest_start_o <= 1'h0;
            test_fail        <= 1'h0;
            err_push_o       <= 1'h0;
            err_code_o       <= BYTE_ZERO;
            trigger_o        <= 1'h0;
        end
        else
        begin
            selftest_start_o <= take_tst;
            test_fail        <= take_tst ? 1'h0 : (test_fail || selftest_err_valid_i);
            err_push_o       <= (state == ST_TEST) && selftest_err_valid_i;
            err_code_o       <= selftest_err_code_i;
            trigger_o        <= trig_fire;
        end
    end

    sequence poll_seq;
        spoll_i && !rqs_set;
    endsequence

    sequence wait_entry_seq;
        take_wai ##1 (state == ST_WAIT);
    endsequence

    property rqs_poll_p;
        @(posedge clk_i) disable iff (!resetn_i)
        poll_seq |=> !srq_o && (mss == $past(next_mss));
    endproperty

    property wait_stall_p;
        @(posedge clk_i) disable iff (!resetn_i)
        wait_entry_seq ##0 (pending_busy_i && !dcl_i) |=> !cmd_ready_o;
    endproperty

    mss_or_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !pon |-> (status_o[BIT_MSS] == |(status_o & mask_o & SUM_MASK)))
        else $error("master summary does not match masked status");

    rqs_poll_a: assert property (rqs_poll_p)
        else $error("serial poll left request bit set");

    zero_mask_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (mask_o == BYTE_ZERO) && $stable(mask_o) && !srq_o && !take_mask
            |=> !srq_o)
        else $error("service request raised with zero mask");

    stb_query_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        take_stq |=> resp_o.valid && (resp_o.data == $past(status_o)))
        else $error("status query returned wrong byte");

    low_bits_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        status_o[2:0] == 3'h0 && spoll_data_o[2:0] == 3'h0)
        else $error("status byte low bits not zero");

    mav_clear_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (take_cls || !oq_has_data_i) |=> !status_o[BIT_MAV])
        else $error("message bit not cleared");

    poll_byte_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        spoll_i |=> spoll_valid_o && spoll_data_o[BIT_MSS] == $past(rqs)
            && spoll_data_o[BIT_OPSUM] == $past(status_o[BIT_OPSUM]))
        else $error("serial poll byte wrong");

    bus_trig_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        trigger_o |-> $past(trig_source_bus_i) && $past(take_trg || get_i))
        else $error("trigger without bus source");

    wait_stall_a: assert property (wait_stall_p)
        else $error("commands accepted during wait");

    wait_abort_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == ST_WAIT) && dcl_i |=> (state == ST_IDLE) ##1 cmd_ready_o)
        else $error("device clear did not abort wait");

    sre_load_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        take_mask ##1 !take_mask[*2] |-> mask_o == $past(cmd_param_i, 2))
        else $error("request mask not loaded");

    test_resp_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state == ST_TEST) && selftest_done_i && !test_fail && !selftest_err_valid_i
            |=> resp_o.valid && resp_o.data == RESP_PASS)
        else $error("self-test pass answer wrong");

endmodule : status_byte_common_commands

`default_nettype wire

// [bench/bus_ctrl_model.sv]
/*
 Behavioural bus controller facing the status byte block: offers decoded
 commands on the valid/ready handshake and strobes serial poll, device
 clear and group execute trigger.
 Assumes the block's clock and callers that act one step after an edge.
*/
`default_nettype none

module bus_ctrl_model
(
    input  wire logic          clk_i,       // Shared system clock
    input  wire logic          cmd_ready_i, // Command accepted by the block
    output var  logic          cmd_valid_o, // Command offered
    output var  sbc_pkg::cmd_t cmd_code_o,  // Command code
    output var  logic [7:0]    cmd_param_o, // Command parameter
    output var  logic          spoll_o,     // Serial poll strobe
    output var  logic          dcl_o,       // Device clear strobe
    output var  logic          get_o        // Group execute trigger strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_pkg::*;

    initial
    begin
        cmd_valid_o = 1'h0;
        cmd_code_o  = CMD_SAV;
        cmd_param_o = 8'h00;
        {get_o, dcl_o, spoll_o} = 3'h0;
    end

    // A nonzero gap makes the controller slow to offer
    task automatic send(input cmd_t code, input logic [7:0] prm, input int gap);
        repeat (gap + 1) @(posedge clk_i);
        #1;
        cmd_code_o  = code;
        cmd_param_o = prm;
        cmd_valid_o = 1'h1;
        for (int i = 0; i < 50 && cmd_ready_i !== 1'h1; i++)
        begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
        #1;
        // Released lines show the inverse so a late sample cannot match by luck
        cmd_valid_o = 1'h0;
        cmd_code_o  = cmd_t'(~code);
        cmd_param_o = ~prm;
    endtask : send

    task automatic strobe(input logic [2:0] which);
        {get_o, dcl_o, spoll_o} = which;
        @(posedge clk_i);
        #1;
        {get_o, dcl_o, spoll_o} = 3'h0;
    endtask : strobe

endmodule : bus_ctrl_model

`default_nettype wire

// [bench/testbench.sv]
/*
 Self-checking bench for the status byte and common command block.
 Assumes the controller model of bus_ctrl_model and one 200 MHz clock.
*/
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_pkg::*;

    logic       clk_i = 1'h0, resetn_i = 1'h0;
    logic       cmd_valid_i, cmd_ready_o, spoll_i, dcl_i, get_i;
    cmd_t       cmd_code_i;
    logic [7:0] cmd_param_i, err_code_o, spoll_data_o, status_o, mask_o;
    settings_t  settings_i = 32'hA5C3_0F96;
    settings_t  restore_data_o;
    summary_t   summary_i = '0;
    resp_t      resp_o;
    logic       power_on_state_select_i = 1'h1, psc_i = 1'h1, oq_has_data_i = 1'h0;
    logic       trig_source_bus_i = 1'h0, pending_busy_i = 1'h0;
    logic       selftest_err_valid_i = 1'h0, selftest_done_i = 1'h0;
    logic [7:0] selftest_err_code_i = 8'h2A;
    logic       restore_valid_o, mask_clear_o, selftest_start_o, err_push_o;
    logic       spoll_valid_o, srq_o, trigger_o;
    int         failures = 0;
    int         cmp_count = 0;

    always #2.5 clk_i = ~clk_i;

    status_byte_common_commands u_status_byte_common_commands (
        .clk_i, .resetn_i, .cmd_valid_i, .cmd_code_i, .cmd_param_i, .cmd_ready_o,
        .settings_i, .power_on_state_select_i, .psc_i, .restore_valid_o,
        .restore_data_o, .mask_clear_o, .summary_i, .oq_has_data_i, .spoll_i, .dcl_i,
        .get_i, .trig_source_bus_i, .pending_busy_i, .selftest_err_valid_i,
        .selftest_err_code_i, .selftest_done_i, .selftest_start_o, .err_push_o,
        .err_code_o, .spoll_valid_o, .spoll_data_o, .resp_o, .status_o, .mask_o, .srq_o,
        .trigger_o
    );

    bus_ctrl_model u_bus_ctrl_model (
        .clk_i, .cmd_ready_i(cmd_ready_o), .cmd_valid_o(cmd_valid_i),
        .cmd_code_o(cmd_code_i), .cmd_param_o(cmd_param_i), .spoll_o(spoll_i),
        .dcl_o(dcl_i), .get_o(get_i)
    );

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task automatic do_reset();
        resetn_i = 1'h0;
        tick(12);
        resetn_i = 1'h1;
        tick(1);
    endtask : do_reset

    task automatic complete_run();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (4000) @(posedge clk_i);
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end

    initial
    begin
        #1;
        do_reset();
        chk(mask_clear_o, 1'h1, "mask clear pulse");
        chk(mask_o, 8'h00, "mask cleared at power-on");
        chk(restore_valid_o, 1'h1, "slot zero recall");
        u_bus_ctrl_model.send(CMD_SAV, 8'h00, 0);
        settings_i = 32'h1234_5678;
        // Out of range slot must not alias onto slot zero
        u_bus_ctrl_model.send(CMD_SAV, 8'h04, 0);
        u_bus_ctrl_model.send(CMD_MASK_SET, 8'h20, 3);
        chk(mask_o, 8'h20, "mask write");
        u_bus_ctrl_model.send(CMD_MASK_QRY, 8'h00, 0);
        chk({resp_o.valid, resp_o.data}, 9'h120, "mask query");
        summary_i.event_summary = 1'h1;
        tick(2);
        chk(status_o, 8'h60, "masked summary");
        chk(srq_o, 1'h1, "request raised");
        u_bus_ctrl_model.send(CMD_STAT_QRY, 8'h00, 0);
        chk({resp_o.valid, resp_o.data}, 9'h160, "status query");
        tick(1);
        chk(status_o, 8'h60, "query keeps byte");
        u_bus_ctrl_model.strobe(3'h1);
        chk({spoll_valid_o, spoll_data_o}, 9'h160, "poll byte");
        chk(srq_o, 1'h0, "request dropped by poll");
        chk(status_o, 8'h60, "summary kept by poll");
        tick(1);
        u_bus_ctrl_model.strobe(3'h1);
        chk(spoll_data_o, 8'h20, "second poll");
        summary_i = '1;
        oq_has_data_i = 1'h1;
        tick(2);
        chk(status_o, 8'hF8, "full layout");
        u_bus_ctrl_model.send(CMD_MASK_SET, 8'h00, 0);
        summary_i = '0;
        tick(2);
        summary_i = '1;
        tick(2);
        chk(status_o, 8'hB8, "zero mask summary");
        chk(srq_o, 1'h0, "zero mask request");
        // Queue still holds data, so only the clear command can drop the bit
        u_bus_ctrl_model.send(CMD_CLS, 8'h00, 0);
        chk(status_o, 8'hA8, "clear drops message bit");
        oq_has_data_i = 1'h0;
        tick(2);
        chk(status_o, 8'hA8, "message bit");
        summary_i = '0;
        tick(2);
        chk(status_o, 8'h00, "summaries cleared");
        u_bus_ctrl_model.send(CMD_TRG, 8'h00, 0);
        chk(trigger_o, 1'h0, "trigger gated");
        trig_source_bus_i = 1'h1;
        u_bus_ctrl_model.send(CMD_TRG, 8'h00, 0);
        chk(trigger_o, 1'h1, "bus trigger");
        u_bus_ctrl_model.strobe(3'h4);
        chk(trigger_o, 1'h1, "group trigger");
        for (int f = 0; f < 2; f++)
        begin
            u_bus_ctrl_model.send(CMD_TST, 8'h00, 0);
            chk(selftest_start_o, 1'h1, "self-test start");
            chk(cmd_ready_o, 1'h0, "busy in self-test");
            selftest_err_valid_i = f[0];
            tick(1);
            selftest_err_valid_i = 1'h0;
            chk(err_push_o, f, "error push");
            if (f == 1) chk(err_code_o, 8'h2A, "error code");
            selftest_done_i = 1'h1;
            tick(1);
            selftest_done_i = 1'h0;
            chk({resp_o.valid, resp_o.data}, 9'h100 | f, "self-test answer");
        end
        pending_busy_i = 1'h1;
        u_bus_ctrl_model.send(CMD_WAI, 8'h00, 0);
        tick(6);
        chk(cmd_ready_o, 1'h0, "wait holds");
        pending_busy_i = 1'h0;
        tick(1);
        chk(cmd_ready_o, 1'h1, "wait released");
        pending_busy_i = 1'h1;
        u_bus_ctrl_model.send(CMD_WAI, 8'h00, 0);
        tick(3);
        u_bus_ctrl_model.strobe(3'h2);
        chk(cmd_ready_o, 1'h1, "device clear ends wait");
        pending_busy_i = 1'h0;
        psc_i = 1'h0;
        u_bus_ctrl_model.send(CMD_MASK_SET, 8'h88, 0);
        do_reset();
        chk(restore_valid_o, 1'h1, "second recall");
        chk(restore_data_o, 32'hA5C3_0F96, "slot zero contents");
        chk(mask_o, 8'h88, "mask restored");
        chk(mask_clear_o, 1'h0, "no mask clear");
        complete_run();
    end

endmodule : testbench

`default_nettype wire
